// [rtl/receive_configuration_pkg.sv]
// Package: register map, field layout and carrier types of the receive acceptance block
package receive_configuration_pkg;
    localparam logic [11:0] RECEIVE_CONFIGURATION_ADDR_CONFIG = 12'h034; // Receive configuration register byte address
    localparam logic [31:0] RECEIVE_CONFIGURATION_RESET_VALUE = 32'h00000002; // Value after hard or soft reset
    localparam logic [31:0] RECEIVE_CONFIGURATION_WRITE_MASK = 32'hD870003E; // Bits that software can change
    localparam int RECEIVE_CONFIGURATION_ACC_ERR_POS = 31; // Accept errored frames
    localparam int RECEIVE_CONFIGURATION_ACC_RUNT_POS = 30; // Accept runt frames
    localparam int RECEIVE_CONFIGURATION_ACC_OWN_TX_POS = 28; // Accept own transmit
    localparam int RECEIVE_CONFIGURATION_ACC_LONG_POS = 27; // Accept long frames
    localparam int RECEIVE_CONFIGURATION_BURST_LSB = 20; // Burst size field low bit
    localparam int RECEIVE_CONFIGURATION_DRAIN_LSB = 1; // Drain threshold field low bit
    localparam logic [11:0] RECEIVE_CONFIGURATION_RUNT_LEN = 12'h040; // 64 bytes, shortest normal frame
    localparam logic [11:0] RECEIVE_CONFIGURATION_STD_MAX_LEN = 12'h5EE; // 1518 bytes incl. CRC
    localparam logic [11:0] RECEIVE_CONFIGURATION_STD_CUT_LEN = 12'h5EA; // 1514 bytes, cut for standard frames
    localparam logic [11:0] RECEIVE_CONFIGURATION_LONG_MAX_LEN = 12'h7FE; // 2046 bytes, cut for long frames
    localparam logic [7:0] RECEIVE_CONFIGURATION_BURST_MAX_WORDS = 8'h80; // Encoding 000 means 128 words
    localparam logic [2:0] RECEIVE_CONFIGURATION_DRAIN_UNIT_SHIFT = 3'h3; // Threshold counts 8-byte units

    // Byte from the receive path
    typedef struct packed {
        logic valid; // Byte present this cycle
        logic [7:0] data; // Byte value
        logic last; // Final byte of the frame
        logic err; // CRC, alignment or collision error at end
        logic coll; // Collision seen on the medium
    } receive_configuration_byte_t;

    // Byte toward the receive FIFO
    typedef struct packed {
        logic valid; // Byte written this cycle
        logic [7:0] data; // Byte value
        logic last; // Frame end marker
    } receive_configuration_fifo_t;

    // Per-frame verdict, one-cycle pulse
    typedef struct packed {
        logic valid; // Verdict present
        logic accept; // Keep frame
        logic reject; // Remove frame from FIFO
        logic err; // Error status for final descriptor
        logic runt; // Runt status
        logic long_f; // Long status
        logic [11:0] len; // Stored length in bytes
    } receive_configuration_verdict_t;
endpackage : receive_configuration_pkg

// [rtl/receive_configuration_regs.sv]
// Receive configuration register behind an APB slave
module receive_configuration_regs (
    input wire logic pclk, // Bus clock, 100 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic soft_reset, // One-cycle soft reset request
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready, always high
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error on unmapped address
    output logic [31:0] cfg // Current configuration word
);
    typedef struct packed {
        logic [31:0] cfg; // Register contents
    } receive_configuration_regs_state_t;
    receive_configuration_regs_state_t st_q, st_d;
    logic hit; // Address decode
    logic wr; // Write takes effect

    assign hit = (paddr == receive_configuration_pkg::RECEIVE_CONFIGURATION_ADDR_CONFIG);
    assign wr = psel && penable && pwrite && hit;
    // Zero-wait slave: answer combinational in the access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = (psel && !pwrite && hit) ? st_q.cfg : 32'h00000000;
    assign cfg = st_q.cfg;

    // Masked write; reserved bits stay zero [R13] [R17]
    always_comb begin
        st_d = st_q;
        if (soft_reset) begin
            st_d.cfg = receive_configuration_pkg::RECEIVE_CONFIGURATION_RESET_VALUE;
        end else if (wr) begin
            st_d.cfg = pwdata & receive_configuration_pkg::RECEIVE_CONFIGURATION_WRITE_MASK; // [R13] [R17]
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{cfg: receive_configuration_pkg::RECEIVE_CONFIGURATION_RESET_VALUE};
        end else begin
            st_q <= st_d;
        end
    end

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q.cfg[29] == 1'b0) && (st_q.cfg[26:23] == 4'h0)) // [R13]
        else $error("reserved bits not zero");
endmodule : receive_configuration_regs

// [rtl/receive_configuration_top.sv]
// Receive frame acceptance: filtering, truncation and DMA burst limit
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: errored frames kept when accept-errored set
// R2: errored frames dropped when accept-errored clear
// R3: late errors reported in final verdict
// R4: error-free runts kept when accept-runt set
// R5: runts dropped when accept-runt clear
// R6: own-transmit data accepted when bit set
// R7: collisions ignored when own-transmit set
// R8: data during transmit rejected when clear
// R9: software sets own-transmit for loopback
// R10: long frames to 2046 normal when allowed
// R11: beyond 2046 cut and marked long
// R12: over 1518 cut at 1514, dropped
// R13: bits 25..23 write-ignored, read zero
// R14: burst size field limits DMA bursts
// R15: encoding 000 is 128, else powers
// R16: drain threshold in 8-byte units
// R17: bits 29 and 26 read zero
//
// Design decision made here: the APB slave port.
module receive_configuration_top (
    input wire logic pclk, // 100 MHz clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic soft_reset, // Soft reset, one-cycle pulse
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire receive_configuration_pkg::receive_configuration_byte_t rx_in, // Received byte stream
    input wire logic tx_active, // Local transmission in progress
    input wire logic [11:0] fifo_level, // Bytes held in receive FIFO
    input wire logic fifo_has_frame, // FIFO holds a complete frame
    output receive_configuration_pkg::receive_configuration_fifo_t fifo_out, // Bytes toward the FIFO
    output receive_configuration_pkg::receive_configuration_verdict_t verdict, // Frame verdict pulse
    output logic [7:0] burst_words, // DMA burst limit in words
    output logic drain_start // FIFO ready to drain
);
    logic [31:0] cfg; // Configuration word
    logic accept_errored_frames; // Control bit
    logic accept_runt_frames; // Control bit
    logic accept_own_transmit; // Control bit
    logic accept_long_frames; // Control bit
    logic [2:0] rx_burst_size_limit; // Burst encoding
    logic [4:0] rx_drain_threshold; // Threshold in 8-byte units
    logic [11:0] drain_bytes; // Threshold in bytes

    typedef struct packed {
        logic [11:0] len; // Bytes seen in frame
        logic in_frame; // Frame in progress
        logic tx_seen; // Own transmit overlapped frame
        logic coll_seen; // Collision during frame
        receive_configuration_pkg::receive_configuration_fifo_t fifo; // Registered FIFO write
        receive_configuration_pkg::receive_configuration_verdict_t verdict; // Registered verdict
        logic [7:0] burst; // Registered burst limit
        logic drain; // Registered drain request
    } receive_configuration_top_state_t;
    receive_configuration_top_state_t st_q, st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    receive_configuration_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .soft_reset(soft_reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .cfg(cfg)
    );

    assign accept_errored_frames = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_ACC_ERR_POS];
    assign accept_runt_frames = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_ACC_RUNT_POS];
    assign accept_own_transmit = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_ACC_OWN_TX_POS];
    assign accept_long_frames = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_ACC_LONG_POS];
    assign rx_burst_size_limit = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_BURST_LSB +: 3];
    assign rx_drain_threshold = cfg[receive_configuration_pkg::RECEIVE_CONFIGURATION_DRAIN_LSB +: 5];
    assign drain_bytes = {4'h0, rx_drain_threshold, 3'h0}; // [R16]

    assign fifo_out = st_q.fifo;
    assign verdict = st_q.verdict;
    assign burst_words = st_q.burst;
    assign drain_start = st_q.drain;

    ////////////////////////////////////////////////////////////////////////////
    // Frame filter: count, cut, and judge at frame end
    always_comb begin
        logic [11:0] cut_len; // Truncation point for this mode
        logic [11:0] len_n; // Length after this byte
        logic over_std; // Frame exceeded 1518 bytes
        logic over_long; // Frame exceeded 2046 bytes
        logic is_runt; // Shorter than 64 bytes
        logic is_err; // Any error counted for this frame
        logic tx_clash; // Overlap with own transmit
        logic keep; // Final decision
        cut_len = 12'h000;
        len_n = 12'h000;
        over_std = 1'b0;
        over_long = 1'b0;
        is_runt = 1'b0;
        is_err = 1'b0;
        tx_clash = 1'b0;
        keep = 1'b0;
        st_d = st_q;
        st_d.fifo = '0;
        st_d.verdict = '0;
        // Mode picks the truncation length
        cut_len = accept_long_frames ? receive_configuration_pkg::RECEIVE_CONFIGURATION_LONG_MAX_LEN // [R11]
                                     : receive_configuration_pkg::RECEIVE_CONFIGURATION_STD_CUT_LEN; // [R12]
        if (rx_in.valid) begin
            len_n = st_q.in_frame ? st_q.len + 12'h001 : 12'h001;
            st_d.in_frame = !rx_in.last;
            st_d.len = len_n;
            // Own transmit and collisions are latched for the whole frame
            st_d.tx_seen = (st_q.in_frame && st_q.tx_seen) || tx_active;
            st_d.coll_seen = (st_q.in_frame && st_q.coll_seen) || rx_in.coll;
            // Bytes past the cut are not written; the end marker still is
            if (len_n <= cut_len || rx_in.last) begin
                st_d.fifo.valid = 1'b1;
                st_d.fifo.data = rx_in.data;
                st_d.fifo.last = rx_in.last;
            end
            if (rx_in.last) begin
                over_std = len_n > receive_configuration_pkg::RECEIVE_CONFIGURATION_STD_MAX_LEN;
                over_long = len_n > receive_configuration_pkg::RECEIVE_CONFIGURATION_LONG_MAX_LEN;
                is_runt = len_n < receive_configuration_pkg::RECEIVE_CONFIGURATION_RUNT_LEN;
                tx_clash = st_d.tx_seen && !accept_own_transmit; // [R8]
                // Collisions count as errors only without own-transmit acceptance
                is_err = rx_in.err || (st_d.coll_seen && !accept_own_transmit); // [R7]
                keep = 1'b1;
                if (is_err && !accept_errored_frames) begin
                    keep = 1'b0; // [R2]
                end
                if (is_runt && !accept_runt_frames) begin
                    keep = 1'b0; // [R5]
                end
                if (is_runt && accept_runt_frames && is_err && !accept_errored_frames) begin
                    keep = 1'b0; // [R4]
                end
                if (tx_clash) begin
                    keep = 1'b0; // [R8]
                end
                if (!accept_long_frames && over_std) begin
                    keep = 1'b0; // [R12]
                end
                st_d.verdict.valid = 1'b1;
                st_d.verdict.accept = keep; // [R1] [R6] [R10]
                st_d.verdict.reject = !keep;
                st_d.verdict.err = is_err; // [R3]
                st_d.verdict.runt = is_runt;
                // Long status: standard mode over 1518, long mode over 2046
                st_d.verdict.long_f = accept_long_frames ? over_long : over_std; // [R10] [R11]
                st_d.verdict.len = (len_n > cut_len) ? cut_len : len_n;
            end
        end
        // Burst limit decode [R14]
        st_d.burst = (rx_burst_size_limit == 3'h0) ? receive_configuration_pkg::RECEIVE_CONFIGURATION_BURST_MAX_WORDS // [R15]
                     : 8'(8'h01 << (rx_burst_size_limit - 3'h1)); // [R15]
        // Drain when threshold reached or whole frame held; zero threshold is illegal
        st_d.drain = fifo_has_frame
                     || (rx_drain_threshold != 5'h00 && fifo_level >= drain_bytes); // [R16]
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else if (soft_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence frame_end_s;
        rx_in.valid && rx_in.last;
    endsequence

    err_drop_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R2]
        frame_end_s and (rx_in.err && !accept_errored_frames) |=> verdict.valid && !verdict.accept)
        else $error("errored frame kept");
    err_keep_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R1]
        frame_end_s and (rx_in.err && accept_errored_frames && accept_own_transmit
        && accept_long_frames && accept_runt_frames) |=> verdict.accept && verdict.err)
        else $error("errored frame dropped");
    runt_drop_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R5]
        verdict.valid && verdict.len < receive_configuration_pkg::RECEIVE_CONFIGURATION_RUNT_LEN && !$past(accept_runt_frames)
        |-> !verdict.accept)
        else $error("runt kept");
    tx_reject_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R8]
        frame_end_s and (tx_active && !accept_own_transmit) |=> verdict.reject)
        else $error("frame during transmit kept");
    std_cut_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R12]
        verdict.valid && !$past(accept_long_frames)
        |-> verdict.len <= receive_configuration_pkg::RECEIVE_CONFIGURATION_STD_CUT_LEN)
        else $error("standard frame not cut");
    long_cut_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R11]
        verdict.valid && verdict.len == receive_configuration_pkg::RECEIVE_CONFIGURATION_LONG_MAX_LEN && $past(st_q.len)
        >= receive_configuration_pkg::RECEIVE_CONFIGURATION_LONG_MAX_LEN |-> verdict.long_f || verdict.reject)
        else $error("over-long frame unmarked");
    burst_max_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R15]
        rx_burst_size_limit == 3'h0 ##1 rx_burst_size_limit == 3'h0
        |-> burst_words == receive_configuration_pkg::RECEIVE_CONFIGURATION_BURST_MAX_WORDS)
        else $error("burst 000 not 128 words");
    burst_one_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R14]
        rx_burst_size_limit == 3'h1 |=> burst_words == 8'h01)
        else $error("burst 001 not one word");
    drain_a: assert property (@(posedge pclk) disable iff (!presetn || soft_reset) // [R16]
        fifo_has_frame |=> drain_start)
        else $error("drain not started");
endmodule : receive_configuration_top

// [bench/rfac_phy_model.sv]
// Physical-layer side model: delivers received frames byte by byte
module rfac_phy_model (
    input wire logic pclk, // Shared receive clock
    output receive_configuration_pkg::receive_configuration_byte_t rx_in, // Byte stream into the block
    output logic tx_active // Local transmit overlapping the frame
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle line at time zero
    initial begin
        rx_in = '0;
        tx_active = 1'b0;
    end

    // Sends n bytes back to back; the error flag rides the last byte only
    task send(input int n, input logic e, input logic c, input logic t);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_in <= '{1'b1, 8'(i * 7 + 3), i == n - 1, e && (i == n - 1), c};
            tx_active <= t;
        end
        @(posedge pclk);
        // Released line shows inverted data so a stale byte cannot pass as fresh
        rx_in <= '{1'b0, ~rx_in.data, 1'b0, 1'b0, 1'b0};
        tx_active <= 1'b0;
    endtask : send
endmodule : rfac_phy_model

// [bench/rx_frame_acceptance_config_tb.sv]
// Self-checking bench for the receive acceptance block
module rx_frame_acceptance_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CFG_ADDR = 12'h034; // Configuration word address
    typedef struct {
        logic [31:0] cfg; // Configuration written before the frame
        int len; // Bytes sent
        logic e, c, t; // Error, collision, transmit overlap
        logic acc, lng; // Expected keep and long mark
        logic [11:0] elen; // Expected stored length
    } rfac_row_t;
    logic pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr, se;
    logic fifo_has_frame, tx_active, drain_start;
    logic [11:0] paddr, fifo_level;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] burst_words;
    receive_configuration_pkg::receive_configuration_byte_t rx_in;
    receive_configuration_pkg::receive_configuration_fifo_t fifo_out;
    receive_configuration_pkg::receive_configuration_verdict_t verdict;
    int err_count = 0, checked = 0, cyc = 0;
    int fcnt = 0; // Bytes written toward the FIFO so far
    // Boundary lengths chosen on purpose: 63/64 runt edge, 1519 just over standard
    rfac_row_t rows [11] = '{
        '{32'h00000002, 64, 0, 0, 0, 1, 0, 12'h040},
        '{32'h00000002, 100, 1, 0, 0, 0, 0, 12'h064},
        '{32'h80000002, 100, 1, 0, 0, 1, 0, 12'h064},
        '{32'h00000002, 63, 0, 0, 0, 0, 0, 12'h03F},
        '{32'h40000002, 63, 0, 0, 0, 1, 0, 12'h03F},
        '{32'h00000002, 100, 0, 0, 1, 0, 0, 12'h064},
        '{32'h10000002, 100, 0, 1, 1, 1, 0, 12'h064},
        '{32'h00000002, 100, 0, 1, 0, 0, 0, 12'h064},
        '{32'h00000002, 1519, 0, 0, 0, 0, 1, 12'h5EA},
        '{32'h08000002, 1600, 0, 0, 0, 1, 0, 12'h640},
        '{32'h08000002, 2100, 0, 0, 0, 1, 1, 12'h7FE}
    };

    receive_configuration_top dut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .rx_in(rx_in), .tx_active(tx_active),
        .fifo_level(fifo_level), .fifo_has_frame(fifo_has_frame), .fifo_out(fifo_out),
        .verdict(verdict), .burst_words(burst_words), .drain_start(drain_start));
    rfac_phy_model phy (.pclk(pclk), .rx_in(rx_in), .tx_active(tx_active));

    ////////////////////////////////////////////////////////////
    // Clock and hang guard; the ceiling is well above the frame traffic
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end

    // FIFO writes counted in the low phase, where the output has settled
    always @(negedge pclk) begin
        if (fifo_out.valid === 1'b1) begin
            fcnt++;
        end
    end

    ////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Verdict is a one-cycle pulse, so look at each low phase for it
    task wait_verdict();
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (verdict.valid !== 1'b1 && n < 8);
        chk(verdict.valid, 1'b1, "no verdict");
    endtask : wait_verdict

    // Sets FIFO status, then checks the registered drain request
    task drain_case(input logic [11:0] lvl, input logic hf, input logic exp);
        @(posedge pclk);
        fifo_level <= lvl;
        fifo_has_frame <= hf;
        repeat (2) @(negedge pclk);
        chk(drain_start, exp, "drain start");
    endtask : drain_case

    task end_sim();
        $display("Checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int base;
        {presetn, soft_reset, psel, penable, pwrite} = '0;
        {paddr, pwdata, fifo_level, fifo_has_frame} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Frame table: configuration, frame, expected verdict
        foreach (rows[i]) begin
            apb(1'b1, CFG_ADDR, rows[i].cfg);
            base = fcnt;
            phy.send(rows[i].len, rows[i].e, rows[i].c, rows[i].t);
            wait_verdict();
            chk({15'h0000, verdict.runt, verdict.accept, verdict.reject, verdict.long_f, verdict.err, verdict.len},
                {15'h0000, rows[i].len < 64, rows[i].acc, ~rows[i].acc, rows[i].lng,
                rows[i].e | (rows[i].c & ~rows[i].cfg[28]), rows[i].elen}, "verdict");
            // Cut frames still write their end marker after the stored bytes
            @(negedge pclk);
            chk(fcnt - base, rows[i].elen + (rows[i].len > rows[i].elen), "fifo bytes");
        end
        // Unused bits read zero whatever is written
        apb(1'b1, CFG_ADDR, 32'hFFFFFFFF);
        apb(1'b0, CFG_ADDR, 32'h00000000);
        chk(rd, 32'hD870003E, "write mask");
        // Unmapped place: error answer, no side effect
        apb(1'b1, 12'h038, 32'h00000000);
        chk(se, 1'b1, "unmapped error");
        apb(1'b0, 12'h038, 32'h00000000);
        chk(rd, 32'h00000000, "unmapped read");
        apb(1'b0, CFG_ADDR, 32'h00000000);
        chk(rd, 32'hD870003E, "unmapped write leaked");
        // Soft reset reloads the default word
        @(posedge pclk);
        soft_reset <= 1'b1;
        @(posedge pclk);
        soft_reset <= 1'b0;
        apb(1'b0, CFG_ADDR, 32'h00000000);
        chk(rd, 32'h00000002, "soft reset value");
        // Every burst encoding
        for (int e = 0; e < 8; e++) begin
            apb(1'b1, CFG_ADDR, 32'h00000002 | (e << 20));
            repeat (2) @(negedge pclk);
            chk(burst_words, (e == 0) ? 8'h80 : 8'h01 << (e - 1), "burst size");
        end
        // Threshold of 4 units is 32 bytes; zero threshold never fires by level
        apb(1'b1, CFG_ADDR, 32'h00000008);
        drain_case(12'h01F, 1'b0, 1'b0);
        drain_case(12'h020, 1'b0, 1'b1);
        drain_case(12'h000, 1'b1, 1'b1);
        apb(1'b1, CFG_ADDR, 32'h00000000);
        drain_case(12'hFFF, 1'b0, 1'b0);
        end_sim();
    end
endmodule : rx_frame_acceptance_config_tb
